// ==== hw/vdh_port_handshake.v ====
// output side and flow-control handshakes of a block convolutional decoder
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "vdh_defs.vh"

module vdh_port_handshake #(
  parameter PAT_W = 12,
  parameter TB_LEN = 42,
  parameter HYB_IDX = 0
) (
  // clock and reset
  input wire clk_in,
  input wire reset_in,
  // apb slave
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output wire pready_out,
  output wire pslverr_out,
  // dynamic settings from the source
  input wire [3:0] inrate_in,
  input wire [4:0] outrate_in,
  input wire [PAT_W-1:0] puncture_pattern_a_in,
  input wire [PAT_W-1:0] puncture_pattern_b_in,
  input wire settings_strobe_in,
  // input block framing
  input wire block_start_in,
  input wire block_end_in,
  // decoded bits from the datapath
  input wire dec_bit_in,
  input wire dec_valid_in,
  input wire dec_last_in,
  input wire dec_err_in,
  output wire dec_ready_out,
  // decoded output stream
  output reg dout_out,
  output reg outvalid_out,
  input wire sink_ready_in,
  output reg out_block_out,
  // error rate report
  output reg [15:0] ber_out,
  output reg ber_valid_out,
  // flow control
  output reg rfib_out,
  // settings in force for the current block
  output reg [3:0] active_inrate_out,
  output reg [4:0] active_outrate_out,
  output reg [PAT_W-1:0] active_pattern_a_out,
  output reg [PAT_W-1:0] active_pattern_b_out
);

  localparam [31:0] RFIB_PERIOD = TB_LEN << HYB_IDX;
  localparam [31:0] RET_CYC_FULL = `VDH_RFIB_RETURN_CYC;
  localparam [3:0] RET_CYC = RET_CYC_FULL[3:0];

  // ==========================================
  // apb slave
  reg [31:0] ctrl;
  wire [1:0] punct_mode = ctrl[`VDH_CTRL_PUNCT_LSB+1:`VDH_CTRL_PUNCT_LSB];
  wire block_mode = ctrl[`VDH_CTRL_BLOCK_BIT];
  wire two_tb = ctrl[`VDH_CTRL_TWO_TB_BIT];
  wire [4:0] ber_exp = ctrl[`VDH_CTRL_BER_EXP_LSB+4:`VDH_CTRL_BER_EXP_LSB];
  wire dyn = (punct_mode == `VDH_PUNCT_DYNAMIC);
  wire fixed = (punct_mode == `VDH_PUNCT_FIXED);
  wire apb_acc = psel_in && penable_in;
  reg addr_ok;

  assign pready_out = 1'b1;
  assign pslverr_out = apb_acc && !addr_ok;

  always @(posedge clk_in) begin
    if (reset_in) begin
      ctrl <= `VDH_CTRL_RESET;
    end else if (apb_acc && pwrite_in && paddr_in == `VDH_OFF_CTRL) begin
      ctrl <= pwdata_in;
    end
  end

  // ==========================================
  // pending and active settings
  reg [3:0] pend_inrate;
  reg [4:0] pend_outrate;
  reg [PAT_W-1:0] pend_a;
  reg [PAT_W-1:0] pend_b;
  reg pend_loaded;

  always @(posedge clk_in) begin
    if (reset_in) begin
      pend_inrate <= 4'h0;
      pend_outrate <= 5'h00;
      pend_a <= {PAT_W{1'b0}};
      pend_b <= {PAT_W{1'b0}};
      pend_loaded <= 1'b0;
      active_inrate_out <= 4'h0;
      active_outrate_out <= 5'h00;
      active_pattern_a_out <= {PAT_W{1'b0}};
      active_pattern_b_out <= {PAT_W{1'b0}};
    end else begin
      if (dyn && settings_strobe_in) begin
        pend_inrate <= inrate_in;
        pend_outrate <= outrate_in;
        pend_a <= puncture_pattern_a_in;
        pend_b <= puncture_pattern_b_in;
        pend_loaded <= 1'b1;
      end
      // only a block start moves settings into force
      if (dyn && block_start_in) begin
        active_inrate_out <= pend_inrate;
        active_outrate_out <= pend_outrate;
        active_pattern_a_out <= pend_a;
        active_pattern_b_out <= pend_b;
      end
    end
  end

  // ==========================================
  // two-entry output buffer
  reg [1:0] buf_bit;
  reg [1:0] buf_last;
  reg [1:0] buf_cnt;
  wire buf_push = dec_valid_in && dec_ready_out;
  wire buf_pop = (buf_cnt != 2'h0) && sink_ready_in;
  wire [1:0] next_buf_cnt = buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop};
  assign dec_ready_out = (buf_cnt != 2'h2);

  always @(posedge clk_in) begin
    if (reset_in) begin
      buf_bit <= 2'h0;
      buf_last <= 2'h0;
      buf_cnt <= 2'h0;
    end else begin
      buf_cnt <= next_buf_cnt;
      if (buf_pop) begin
        buf_bit[0] <= buf_bit[1];
        buf_last[0] <= buf_last[1];
      end
      if (buf_push) begin
        if (buf_cnt == 2'h0 || (buf_cnt == 2'h1 && buf_pop)) begin
          buf_bit[0] <= dec_bit_in;
          buf_last[0] <= dec_last_in;
        end else begin
          buf_bit[1] <= dec_bit_in;
          buf_last[1] <= dec_last_in;
        end
      end
    end
  end

  // ==========================================
  // decoded output and block framing
  reg in_out_block;
  wire blk_flag_ok = (punct_mode != `VDH_PUNCT_NONE) || block_mode;

  always @(posedge clk_in) begin
    if (reset_in) begin
      dout_out <= 1'b0;
      outvalid_out <= 1'b0;
      out_block_out <= 1'b0;
      in_out_block <= 1'b0;
    end else begin
      outvalid_out <= buf_pop;
      if (buf_pop) begin
        dout_out <= buf_bit[0];
      end
      // flag holds through gaps until the block's last bit leaves
      if (buf_pop) begin
        in_out_block <= !buf_last[0];
        out_block_out <= blk_flag_ok;
      end else if (!in_out_block) begin
        out_block_out <= 1'b0;
      end
    end
  end

  // ==========================================
  // error rate monitor, continuous decoding only
  reg [31:0] ber_period_cnt;
  reg [15:0] ber_acc;
  wire [31:0] ber_period = 32'h0000_0001 << ber_exp;
  wire ber_end = (ber_period_cnt >= ber_period - 32'h0000_0001);

  always @(posedge clk_in) begin
    if (reset_in) begin
      ber_period_cnt <= 32'h0000_0000;
      ber_acc <= 16'h0000;
      ber_out <= 16'h0000;
      ber_valid_out <= 1'b0;
    end else if (block_mode) begin
      ber_period_cnt <= 32'h0000_0000;
      ber_acc <= 16'h0000;
      ber_valid_out <= 1'b0;
    end else begin
      ber_valid_out <= ber_end;
      if (ber_end) begin
        ber_period_cnt <= 32'h0000_0000;
        // saturate so a noisy period never wraps to a clean-looking count
        if (dec_err_in && ber_acc != 16'hffff) begin
          ber_out <= ber_acc + 16'h0001;
        end else begin
          ber_out <= ber_acc;
        end
        ber_acc <= 16'h0000;
      end else begin
        ber_period_cnt <= ber_period_cnt + 32'h0000_0001;
        if (dec_err_in && ber_acc != 16'hffff) begin
          ber_acc <= ber_acc + 16'h0001;
        end
      end
    end
  end

  // ==========================================
  // ready for input block
  localparam RS_IDLE = 2'h0;
  localparam RS_RECV = 2'h1;
  localparam RS_DRAIN = 2'h2;
  reg [1:0] rstate;
  reg [3:0] ret_cnt;
  reg [31:0] period_cnt;
  wire rfib_fixed_ok = fixed && block_mode && two_tb;

  always @(posedge clk_in) begin
    if (reset_in) begin
      rstate <= RS_IDLE;
      ret_cnt <= 4'h0;
      period_cnt <= 32'h0000_0000;
      rfib_out <= 1'b0;
    end else if (dyn) begin
      case (rstate)
        RS_IDLE: begin
          // held low until the first settings arrive
          rfib_out <= pend_loaded;
          if (block_start_in) begin
            rstate <= block_end_in ? RS_DRAIN : RS_RECV;
            rfib_out <= 1'b0;
            ret_cnt <= 4'h0;
          end
        end
        RS_RECV: begin
          rfib_out <= 1'b0;
          if (block_end_in) begin
            rstate <= RS_DRAIN;
            ret_cnt <= 4'h0;
          end
        end
        RS_DRAIN: begin
          ret_cnt <= ret_cnt + 4'h1;
          if (ret_cnt + 4'h1 >= RET_CYC) begin
            rstate <= RS_IDLE;
            rfib_out <= 1'b1;
          end
        end
        default: begin
          rstate <= RS_IDLE;
        end
      endcase
    end else if (rfib_fixed_ok) begin
      rstate <= RS_IDLE;
      if (block_start_in || period_cnt >= RFIB_PERIOD - 32'h0000_0001) begin
        period_cnt <= 32'h0000_0000;
      end else begin
        period_cnt <= period_cnt + 32'h0000_0001;
      end
      rfib_out <= !block_start_in && (period_cnt == RFIB_PERIOD - 32'h0000_0002);
    end else begin
      rstate <= RS_IDLE;
      period_cnt <= 32'h0000_0000;
      rfib_out <= 1'b0;
    end
  end

  // ==========================================
  // apb read mux
  always @* begin
    addr_ok = 1'b1;
    prdata_out = 32'h0000_0000;
    case (paddr_in)
      `VDH_OFF_CTRL: prdata_out = ctrl;
      `VDH_OFF_RATES: prdata_out = {16'h0000, 3'h0, pend_outrate, 4'h0, pend_inrate};
      `VDH_OFF_PATTERNS: prdata_out = {{(16-PAT_W){1'b0}}, pend_b, {(16-PAT_W){1'b0}}, pend_a};
      `VDH_OFF_STATUS: prdata_out = {24'h0000_00, 2'h0, rstate, buf_cnt, pend_loaded, rfib_out};
      `VDH_OFF_BER: prdata_out = {16'h0000, ber_out};
      `VDH_OFF_PARAMS: prdata_out = RFIB_PERIOD;
      default: addr_ok = 1'b0;
    endcase
  end

endmodule // vdh_port_handshake

// ==== pkg/vdh_defs.vh ====
// constants for the decoder port handshake block
`ifndef VDH_DEFS_VH
`define VDH_DEFS_VH

// ==========================================
// apb register byte offsets
`define VDH_OFF_CTRL 12'h000
`define VDH_OFF_RATES 12'h004
`define VDH_OFF_PATTERNS 12'h008
`define VDH_OFF_STATUS 12'h00c
`define VDH_OFF_BER 12'h010
`define VDH_OFF_PARAMS 12'h014

// ==========================================
// control register fields
`define VDH_CTRL_PUNCT_LSB 0
`define VDH_CTRL_BLOCK_BIT 2
`define VDH_CTRL_TWO_TB_BIT 3
`define VDH_CTRL_BER_EXP_LSB 4
`define VDH_CTRL_RESET 32'h0000_0000

// puncturing modes
`define VDH_PUNCT_NONE 2'h0
`define VDH_PUNCT_FIXED 2'h1
`define VDH_PUNCT_DYNAMIC 2'h2

// ==========================================
// timing counts
`define VDH_RFIB_RETURN_NS 15
`define VDH_CLK_PERIOD_NS 5
`define VDH_RFIB_RETURN_CYC ((`VDH_RFIB_RETURN_NS + `VDH_CLK_PERIOD_NS - 1) / `VDH_CLK_PERIOD_NS)

`endif

// ==== test/vdh_chk.sv ====
// assertion checker for the decoder port handshake block
`timescale 1ns/1ps
module vdh_chk (
  // clock, reset, apb
  input wire clk_in,
  input wire reset_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  // framing and stream
  input wire block_start_in,
  input wire block_end_in,
  input wire sink_ready_in,
  input wire outvalid_out,
  input wire out_block_out,
  input wire ber_valid_out,
  input wire rfib_out,
  input wire [3:0] active_inrate_out
);
  // ====
  // shadow of control fields
  reg [1:0] md;
  reg bm, blk, seen;
  reg [4:0] ex;
  reg [15:0] cnt;
  wire wr = psel_in & penable_in & pwrite_in & (paddr_in == 12'h000);
  wire dyn = md == 2'h2;
  always @(posedge clk_in) begin
    if (reset_in) begin
      {md, bm, ex, blk, seen, cnt} <= 26'h000_0000;
    end else begin
      if (wr) begin
        {ex, bm, md} <= {pwdata_in[8:4], pwdata_in[2], pwdata_in[1:0]};
        seen <= 1'b0;
      end else if (ber_valid_out) begin
        seen <= 1'b1;
      end
      // first pulse after a write only restarts the count
      cnt <= (ber_valid_out | wr) ? 16'h0000 : cnt + 16'h0001;
      blk <= block_start_in | (blk & ~block_end_in);
    end
  end
  // ====
  // properties
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  AST_RFIB_DROP: assert property (dyn && block_start_in |=> !rfib_out) else $error("ready high after start");
  AST_RFIB_HOLD: assert property (dyn && blk |-> !rfib_out) else $error("ready high in block");
  AST_RFIB_BACK: assert property (dyn && block_end_in |-> ##[1:5] rfib_out) else $error("ready late");
  AST_RFIB_NONE: assert property (md == 2'h0 |-> !rfib_out) else $error("ready unpunctured");
  AST_RFIB_GAP: assert property (md == 2'h1 && rfib_out |=> !rfib_out [*8]) else $error("ready gap");
  AST_OBLK_OFF: assert property (md == 2'h0 && !bm |-> !out_block_out) else $error("block flag");
  AST_OBLK_FIRST: assert property ($rose(out_block_out) |-> outvalid_out) else $error("block flag early");
  AST_BER_OFF: assert property (bm && $past(bm) |-> !ber_valid_out) else $error("rate in block");
  AST_BER_PERIOD: assert property (ber_valid_out && seen |-> cnt == (16'h0001 << ex) - 16'h0001)
    else $error("rate period");
  AST_OUT_POP: assert property (outvalid_out |-> $past(sink_ready_in)) else $error("bit unasked");
  AST_ACT_HOLD: assert property (!$past(block_start_in) |-> $stable(active_inrate_out)) else $error("early");
  COV_DYN: cover property (dyn && block_end_in ##[1:5] rfib_out);
  COV_FIXED: cover property (md == 2'h1 && rfib_out);
  COV_STALL: cover property (outvalid_out ##1 !sink_ready_in);
endmodule // vdh_chk
bind vdh_port_handshake vdh_chk u_chk (.*);

// ==== test/vdh_partner.sv ====
// partner model: decoded-bit producer and stalling consumer
`timescale 1ns/1ps
module vdh_partner (
  // clock, reset, trigger
  input wire clk_in,
  input wire reset_in,
  input wire go_in,
  // producer
  input wire dec_ready_in,
  output reg dec_bit_out = 1'b0,
  output reg dec_valid_out = 1'b0,
  output reg dec_last_out = 1'b0,
  // consumer
  output reg sink_ready_out = 1'b0
);
  // ====
  // twenty bits per trigger
  reg [4:0] rem;
  reg [2:0] tick;
  always @(posedge clk_in) begin
    tick <= reset_in ? 3'h0 : tick + 3'h1;
    // half rate so the buffer fills
    sink_ready_out <= !reset_in && tick[2];
    if (reset_in) begin
      {rem, dec_bit_out, dec_valid_out, dec_last_out} <= 8'h00;
    end else if (go_in) begin
      rem <= 5'h14;
    end else if (!dec_valid_out || dec_ready_in) begin
      dec_valid_out <= rem != 5'h00;
      // idle line toggles, never holds
      dec_bit_out <= (rem != 5'h00) ? rem[0] ^ rem[2] : ~dec_bit_out;
      dec_last_out <= rem == 5'h01;
      rem <= (rem != 5'h00) ? rem - 5'h01 : rem;
    end
  end
endmodule // vdh_partner

// ==== test/vdh_port_handshake_tb.sv ====
// testbench for the decoder port handshake block
`timescale 1ns/1ps
`include "vdh_defs.vh"
`define CHK(n, g, x) begin checks++; if ((g) !== (x)) begin miscompares++; $display("[FAIL] %s exp %0h got %0h", n, x, g); end end
module vdh_port_handshake_tb;
  // ====
  // signals
  logic clk_in = 0, reset_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0, go = 0, inblk = 0, full = 0, e;
  logic settings_strobe_in = 0, block_start_in = 0, block_end_in = 0, dec_err_in = 0;
  logic [11:0] paddr_in = 0, puncture_pattern_a_in = 0, puncture_pattern_b_in = 0;
  logic [11:0] active_pattern_a_out, active_pattern_b_out;
  logic [31:0] pwdata_in = 0, prdata_out, q;
  logic [3:0] inrate_in = 0, active_inrate_out;
  logic [4:0] outrate_in = 0, active_outrate_out;
  logic [15:0] ber_out;
  logic pready_out, pslverr_out, dec_bit_in, dec_valid_in, dec_last_in, dec_ready_out, dout_out, outvalid_out;
  logic sink_ready_in, out_block_out, ber_valid_out, rfib_out;
  int checks = 0, miscompares = 0, nbit = 0, n, m;
  always #2.5 clk_in = ~clk_in;
  vdh_port_handshake #(.TB_LEN(6), .HYB_IDX(1)) dut (.*);
  vdh_partner model (.clk_in(clk_in), .reset_in(reset_in), .go_in(go), .dec_ready_in(dec_ready_out),
    .dec_bit_out(dec_bit_in), .dec_valid_out(dec_valid_in), .dec_last_out(dec_last_in), .sink_ready_out(sink_ready_in));
  always @(posedge clk_in) begin
    if (dec_valid_in && !dec_ready_out) full <= 1;
    if (outvalid_out) begin
      m = 20 - nbit;
      `CHK("dout", dout_out, m[0] ^ m[2])
      if (inblk) `CHK("block flag", out_block_out, 1'b1)
      nbit <= nbit + 1;
    end
  end
  // ====
  // access tasks
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {2'b10, w, a, d};
    @(posedge clk_in);
    penable_in <= 1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    {e, q} = {pslverr_out, prdata_out};
    {psel_in, penable_in} <= 2'b00;
  endtask
  task pulse(input int k);
    @(posedge clk_in);
    {block_start_in, block_end_in, settings_strobe_in} <= 3'b100 >> k;
    @(posedge clk_in);
    {block_start_in, block_end_in, settings_strobe_in} <= 3'b000;
  endtask
  task wt(input logic r);
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while ((r ? rfib_out : ber_valid_out) !== 1'b1 && n < 300);
    `CHK("wait", n < 300, 1'b1)
  endtask
  task set(input logic [3:0] i, input logic [4:0] o, input logic [11:0] a, b);
    {inrate_in, outrate_in, puncture_pattern_a_in, puncture_pattern_b_in} <= {i, o, a, b};
    pulse(2);
  endtask
  task go_bits;
    nbit = 0;
    go <= 1;
    @(posedge clk_in);
    go <= 0;
  endtask
  task end_sim;
    if (miscompares == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ====
  // sequence
  initial begin
    repeat (6) @(posedge clk_in);
    reset_in <= 0;
    apb(0, `VDH_OFF_CTRL, 0);
    `CHK("ctrl reset", q, `VDH_CTRL_RESET)
    apb(0, 12'h018, 0);
    `CHK("unmapped", {e, q}, {1'b1, 32'h0000_0000})
    apb(1, `VDH_OFF_CTRL, 32'h0000_0040);
    apb(0, `VDH_OFF_CTRL, 0);
    `CHK("ctrl", q, 32'h0000_0040)
    dec_err_in <= 1;
    repeat (3) wt(0);
    `CHK("ber period", n, 16)
    `CHK("ber", ber_out, 16'h0010)
    dec_err_in <= 0;
    go_bits();
    repeat (80) @(posedge clk_in);
    `CHK("bits", nbit, 20)
    `CHK("stall", full, 1'b1)
    apb(0, `VDH_OFF_STATUS, 0);
    `CHK("drained", q[3:0], 4'h0)
    apb(1, `VDH_OFF_CTRL, 32'h0000_000d);
    pulse(0);
    pulse(1);
    wt(1);
    wt(1);
    `CHK("fixed period", n, 12)
    apb(0, `VDH_OFF_PARAMS, 0);
    `CHK("period reg", q, 32'h0000_000c)
    apb(1, `VDH_OFF_CTRL, 32'h0000_0006);
    repeat (10) @(posedge clk_in);
    set(4'h3, 5'h04, 12'h007, 12'h001);
    apb(0, `VDH_OFF_RATES, 0);
    `CHK("rates", q, 32'h0000_0403)
    apb(0, `VDH_OFF_PATTERNS, 0);
    `CHK("patterns", q, 32'h0001_0007)
    wt(1);
    pulse(0);
    @(posedge clk_in);
    `CHK("ready busy", rfib_out, 1'b0)
    `CHK("active", {active_inrate_out, active_outrate_out, active_pattern_a_out, active_pattern_b_out},
      {4'h3, 5'h04, 12'h007, 12'h001})
    inblk <= 1;
    go_bits();
    set(4'h1, 5'h02, 12'h001, 12'h001);
    `CHK("held", active_inrate_out, 4'h3)
    repeat (60) @(posedge clk_in);
    `CHK("block end", {out_block_out, nbit}, {1'b0, 32'd20})
    inblk <= 0;
    pulse(1);
    wt(1);
    `CHK("ready back", n, `VDH_RFIB_RETURN_CYC + 1)
    pulse(0);
    @(posedge clk_in);
    `CHK("next settings", active_inrate_out, 4'h1)
    end_sim();
  end
  initial begin
    repeat (3000) @(posedge clk_in);
    miscompares++;
    end_sim();
  end
endmodule // vdh_port_handshake_tb
